// file: prs_shifter.sv
`timescale 1ns/1ps
// Function
// - variable rounding word shift: arithmetic shift of second source, round
// - variable word count is first source bits four to zero
// - immediate rounding word shift: arithmetic shift by immediate, round
// - 33-bit intermediate, add one, keep bits 32 to 1
// - immediate halfword pair shift: each halfword zero filled, own lane
// - immediate halfword count is four bits, zero to fifteen
// - variable halfword pair shift zero fills both halfwords
// - variable halfword count is first source bits three to zero
// - immediate quad byte logical shift, each byte zero filled
// - variable quad byte logical shift, each byte zero filled
// - variable byte count is first source bits two to zero
// - arithmetic byte shift: zero count passes, else sign filled
// - rounding byte shift, zero count appends one zero guard bit
// - reserved trap if unsupported, disabled trap if disabled
// - no exception ever depends on operands, counts or results
module prs_shifter
  import prs_pkg::*;
#(
  parameter bit HAS_EXT = 1'b1,
  parameter bit HAS_REV2 = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire prs_pkg::prs_op_t i_op,
  input wire logic [31:0] i_source_reg_a,
  input wire logic [31:0] i_second_reg_field,
  input wire logic [4:0] i_shift_amount,
  input wire logic [4:0] i_dest_idx,
  input wire logic [4:0] i_src_idx,
  input wire logic i_ext_enable,
  input wire logic i_rev2_enable,
  output logic o_valid,
  output logic [31:0] o_result,
  output logic o_wr_en,
  output logic [4:0] o_wr_idx,
  output logic o_exc,
  output prs_pkg::prs_exc_t o_exc_cause
);
  import prs_pkg::*;

  typedef struct packed {
    logic valid;
    logic [31:0] result;
    logic wr_en;
    logic [4:0] wr_idx;
    logic exc;
    prs_exc_t cause;
  } prs_state_t;

  prs_state_t st_r;
  prs_state_t st_nxt;

  // count field per element width
  logic [4:0] cnt_word;
  logic [3:0] cnt_half;
  logic [2:0] cnt_byte;
  logic arith;
  logic round_b;
  logic [31:0] word_data;
  logic [31:0] half_res;
  logic [31:0] byte_res;
  logic [31:0] word_res;

  // operation belongs to the second revision
  function automatic logic is_rev2(input prs_op_t op);
    return PRS_REV2_MASK[op];
  endfunction

  // immediate forms take their operand from the source field
  function automatic logic is_imm(input prs_op_t op);
    return (op == PRS_OP_IMM_ROUND_WORD) || (op == PRS_OP_IMM_HALF_PAIR) ||
      (op == PRS_OP_IMM_QUAD_BYTE);
  endfunction

  // counts: immediate field or low bits of the first source
  always_comb begin
    if (is_imm(i_op)) begin
      cnt_word = i_shift_amount;
      cnt_half = i_shift_amount[PRS_HALF_CNT_W-1:0];
      cnt_byte = i_shift_amount[PRS_BYTE_CNT_W-1:0];
      word_data = i_source_reg_a;
    end else begin
      cnt_word = i_source_reg_a[PRS_WORD_CNT_W-1:0];
      cnt_half = i_source_reg_a[PRS_HALF_CNT_W-1:0];
      cnt_byte = i_source_reg_a[PRS_BYTE_CNT_W-1:0];
      word_data = i_second_reg_field;
    end
    arith = (i_op == PRS_OP_VAR_ARITH_BYTE) ||
      (i_op == PRS_OP_VAR_ROUND_BYTE);
    round_b = (i_op == PRS_OP_VAR_ROUND_BYTE);
  end

  // word lane: sign extended guard-bit shift then round
  prs_lane_shift #(
    .W(PRS_WORD_W),
    .CW(PRS_WORD_CNT_W)
  ) u_word (
    .i_value(word_data),
    .i_count(cnt_word),
    .i_arith(1'b1),
    .i_round(1'b1),
    .o_result(word_res)
  );

  // halfword and byte lanes share one generated structure
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      prs_lane_shift #(
        .W(PRS_HALF_W),
        .CW(PRS_HALF_CNT_W)
      ) u_half (
        .i_value(word_data[g*16 +: 16]),
        .i_count(cnt_half),
        .i_arith(1'b0),
        .i_round(1'b0),
        .o_result(half_res[g*16 +: 16])
      );
    end
    for (g = 0; g < 4; g++) begin : g_byte
      prs_lane_shift #(
        .W(PRS_BYTE_W),
        .CW(PRS_BYTE_CNT_W)
      ) u_byte (
        .i_value(word_data[g*8 +: 8]),
        .i_count(cnt_byte),
        .i_arith(arith),
        .i_round(round_b),
        .o_result(byte_res[g*8 +: 8])
      );
    end
  endgenerate

  // result select and access check; data never reaches the trap logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = i_valid;
    st_nxt.wr_en = 1'b0;
    st_nxt.exc = 1'b0;
    st_nxt.cause = PRS_EXC_NONE;
    st_nxt.wr_idx = is_imm(i_op) ? i_src_idx : i_dest_idx;
    case (i_op)
      PRS_OP_VAR_ROUND_WORD: st_nxt.result = word_res;
      PRS_OP_IMM_ROUND_WORD: st_nxt.result = word_res;
      PRS_OP_IMM_HALF_PAIR: st_nxt.result = half_res;
      PRS_OP_VAR_HALF_PAIR: st_nxt.result = half_res;
      default: st_nxt.result = byte_res;
    endcase
    if (i_valid) begin
      if (!HAS_EXT || (is_rev2(i_op) && !HAS_REV2)) begin
        st_nxt.exc = 1'b1;
        st_nxt.cause = PRS_EXC_RESERVED;
      end else if (!i_ext_enable || (is_rev2(i_op) && !i_rev2_enable)) begin
        st_nxt.exc = 1'b1;
        st_nxt.cause = PRS_EXC_DISABLED;
      end else begin
        st_nxt.wr_en = 1'b1;
      end
    end
    if (!st_nxt.wr_en) begin
      st_nxt.result = PRS_RESULT_RST; // nothing stale leaks on a trap
    end
  end

  // single state register, one cycle latency
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r.valid <= 1'b0;
      st_r.result <= PRS_RESULT_RST;
      st_r.wr_en <= 1'b0;
      st_r.wr_idx <= PRS_IDX_RST;
      st_r.exc <= 1'b0;
      st_r.cause <= PRS_EXC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_valid = st_r.valid;
  assign o_result = st_r.result;
  assign o_wr_en = st_r.wr_en;
  assign o_wr_idx = st_r.wr_idx;
  assign o_exc = st_r.exc;
  assign o_exc_cause = st_r.cause;
endmodule // prs_shifter

// file: prs_pkg.sv
package prs_pkg;
  // operation select codes presented by the pipeline
  typedef enum logic [2:0] {
    PRS_OP_VAR_ROUND_WORD,
    PRS_OP_IMM_ROUND_WORD,
    PRS_OP_IMM_HALF_PAIR,
    PRS_OP_VAR_HALF_PAIR,
    PRS_OP_IMM_QUAD_BYTE,
    PRS_OP_VAR_QUAD_BYTE,
    PRS_OP_VAR_ARITH_BYTE,
    PRS_OP_VAR_ROUND_BYTE
  } prs_op_t;

  // exception cause reported with a refused operation
  typedef enum logic [1:0] {
    PRS_EXC_NONE,
    PRS_EXC_RESERVED,
    PRS_EXC_DISABLED
  } prs_exc_t;

  localparam int PRS_WORD_W = 32;
  localparam int PRS_HALF_W = 16;
  localparam int PRS_BYTE_W = 8;
  localparam int PRS_WORD_CNT_W = 5;
  localparam int PRS_HALF_CNT_W = 4;
  localparam int PRS_BYTE_CNT_W = 3;
  localparam int PRS_REG_IDX_W = 5;
  localparam logic [31:0] PRS_RESULT_RST = 32'h0000_0000;
  localparam logic [4:0] PRS_IDX_RST = 5'h00;
  // revision level of each operation: one = base, two = second revision
  // the variable quad byte logical shift is a base operation
  localparam logic [7:0] PRS_REV2_MASK = 8'hDC;
endpackage : prs_pkg

// file: prs_lane_shift.sv
`timescale 1ns/1ps
// one element lane: logical, arithmetic or rounding arithmetic right shift
module prs_lane_shift #(
  parameter int W = 8,
  parameter int CW = 3
) (
  input wire logic [W-1:0] i_value,
  input wire logic [CW-1:0] i_count,
  input wire logic i_arith,
  input wire logic i_round,
  output logic [W-1:0] o_result
);
  logic [W:0] ext;
  logic [W:0] shifted;
  logic [W:0] rounded;

  // the value carries one guard bit below its lsb so rounding falls out
  // of a single add; a zero count leaves the guard at zero
  always_comb begin
    ext = {i_value, 1'b0};
    if (i_arith) begin
      // kept out of any mixed expression so the shift stays arithmetic
      shifted = $signed(ext) >>> i_count;
    end else begin
      shifted = ext >> i_count;
    end
    if (i_round) begin
      rounded = shifted + (W+1)'(1);
    end else begin
      rounded = shifted;
    end
    o_result = rounded[W:1];
  end
endmodule // prs_lane_shift

// file: prs_regfile_model.sv
`timescale 1ns/1ps
// writeback side: register file taking results
module prs_regfile_model (
  input wire logic i_sys_clk,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_idx,
  input wire logic [31:0] i_wr_data
);
  logic [31:0] regs [32];
  // a refused op never reaches the file
  always @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      regs[i_wr_idx] <= i_wr_data;
    end
  end
endmodule // prs_regfile_model

// file: prs_shifter_properties.sv
`timescale 1ns/1ps
module prs_shifter_properties
  import prs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire prs_pkg::prs_op_t i_op,
  input wire logic [4:0] i_src_idx,
  input wire logic i_ext_enable,
  input wire logic i_rev2_enable,
  input wire logic o_valid,
  input wire logic [31:0] o_result,
  input wire logic o_wr_en,
  input wire logic [4:0] o_wr_idx,
  input wire logic o_exc,
  input wire prs_pkg::prs_exc_t o_exc_cause
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // accepted op: enabled and revision enabled or not needed
  sequence ok_req_s;
    i_valid && i_ext_enable && (i_rev2_enable || !PRS_REV2_MASK[i_op]);
  endsequence
  sequence imm_word_s;
    i_valid && i_op == PRS_OP_IMM_ROUND_WORD ##1 o_wr_en;
  endsequence
  answer_on_time_a: assert property ($past(i_valid) == o_valid)
    else $error("answer not one cycle after request");
  one_outcome_a: assert property (o_valid |-> o_wr_en != o_exc)
    else $error("answer lacks single outcome");
  idle_quiet_a: assert property (!o_valid |-> !o_wr_en && !o_exc)
    else $error("strobe without answer");
  trap_clean_a: assert property (o_exc |-> o_result == 0)
    else $error("trap carries a result");
  disabled_trap_a: assert property (i_valid && !i_ext_enable |=>
    o_exc && o_exc_cause == PRS_EXC_DISABLED) else $error("no disabled trap");
  no_data_trap_a: assert property (ok_req_s |=> o_wr_en)
    else $error("accepted op trapped");
  rev_trap_a: assert property (i_valid && i_ext_enable && !i_rev2_enable
    && PRS_REV2_MASK[i_op] |=> o_exc) else $error("revision op ran");
  dest_field_a: assert property (imm_word_s |-> o_wr_idx == $past(i_src_idx))
    else $error("immediate word wrong index");
endmodule // prs_shifter_properties
bind prs_shifter prs_shifter_properties u_prop (.*);

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import prs_pkg::*;
  logic clk = 0, rst_n = 0, vld = 0, ext = 1, r2 = 1, ov, we, ex;
  prs_op_t op = PRS_OP_VAR_ROUND_WORD;
  prs_exc_t cs;
  logic [31:0] a = 0, b = 0, res, lf = 32'h0001_4E52;
  logic [4:0] s = 0, di = 0, si = 0, wi;
  int bad_count = 0, comparisons = 0;
  prs_shifter uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_valid(vld),
    .i_op(op), .i_source_reg_a(a), .i_second_reg_field(b),
    .i_shift_amount(s), .i_dest_idx(di), .i_src_idx(si), .i_ext_enable(ext),
    .i_rev2_enable(r2), .o_valid(ov), .o_result(res), .o_wr_en(we),
    .o_wr_idx(wi), .o_exc(ex), .o_exc_cause(cs));
  prs_regfile_model rf (.i_sys_clk(clk), .i_wr_en(we), .i_wr_idx(wi),
    .i_wr_data(res));
  initial forever #50 clk = ~clk;
  function logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // guard bit below each lane gives the rounding
  function logic [31:0] ex_f(prs_op_t o, logic [31:0] x, y, logic [4:0] c);
    logic [32:0] t; logic [8:0] e; logic [31:0] r, d; logic im;
    im = o inside {PRS_OP_IMM_ROUND_WORD, PRS_OP_IMM_HALF_PAIR,
      PRS_OP_IMM_QUAD_BYTE};
    d = im ? x : y;
    c = im ? c : x[4:0];
    t = ($signed({d, 1'b0}) >>> c) + 1;
    if (o < PRS_OP_IMM_HALF_PAIR) return t[32:1];
    for (int g = 0; g < 2; g++) r[16*g+:16] = d[16*g+:16] >> c[3:0];
    if (o < PRS_OP_IMM_QUAD_BYTE) return r;
    for (int g = 0; g < 4; g++) begin
      e = $signed({d[8*g+:8], 1'b0}) >>> c[2:0];
      if (o == 7) e = e + 9'h001;
      r[8*g+:8] = (o < 6) ? d[8*g+:8] >> c[2:0] : e[8:1];
    end
    return r;
  endfunction
  task chk(string n, logic [31:0] seen, expv);
    comparisons++;
    if (seen !== expv) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, expv, seen);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task run(prs_op_t o, logic [31:0] x, y, logic [4:0] c, logic e, f);
    logic tr;
    logic [4:0] w;
    tr = !e || (!f && PRS_REV2_MASK[o]);
    @(posedge clk);
    op <= o; a <= x; b <= y; s <= c; ext <= e; r2 <= f; vld <= 1;
    di <= x[9:5]; si <= y[14:10];
    @(posedge clk);
    vld <= 0;
    #1;
    chk("valid", ov, 1);
    chk("trap", ex, tr);
    chk("cause", cs, tr ? PRS_EXC_DISABLED : PRS_EXC_NONE);
    chk("result", res, tr ? 0 : ex_f(o, x, y, c));
    if (!tr) begin
      chk("index", wi, o inside {1, 2, 4} ? y[14:10] : x[9:5]);
      // the file takes the strobe one edge after it appears
      w = wi;
      @(posedge clk);
      #1;
      chk("regfile", rf.regs[w], ex_f(o, x, y, c));
    end
  endtask
  // random operands, first two of each op pin count to zero and max
  initial begin
    logic [31:0] x, y;
    logic [4:0] c;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    for (int o = 0; o < 8; o++) for (int k = 0; k < 12; k++) begin
      lf = nx(lf); x = lf; lf = nx(lf); y = lf; c = lf[20:16];
      if (k < 2) begin x[4:0] = {5{k[0]}}; c = {5{k[0]}}; end
      run(prs_op_t'(o), x, y, c, 1, 1);
    end
    $display("test shifts done");
    for (int o = 0; o < 8; o++) begin
      run(prs_op_t'(o), lf, ~lf, 3, 0, 1);
      run(prs_op_t'(o), ~lf, lf, 5, 1, 0);
    end
    $display("test traps done");
    summarize;
  end
  initial begin
    repeat (1000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule // testbench
